// file: mod_sideband_pkg.sv
// Shared constants for the module sideband control link and both of its ends
package mod_sideband_pkg;
	// Clock rates and link timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCL_PERIOD_NS = 160;
	localparam int QUARTER_CYC   = (SCL_PERIOD_NS / (4 * CLK_PERIOD_NS)) < 1 ?
		1 : SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	// Reset filter and management init counts, in clk cycles
	localparam int RST_FILTER_CYC = 100;
	localparam int INIT_CYC       = 1000;
	// Frame layout, counted in serial clock rising edges
	localparam logic [4:0] ADDR_DONE  = 5'h08;
	localparam logic [4:0] DATA_DONE  = 5'h11;
	localparam logic [4:0] FRAME_BITS = 5'h12;
	// Module register indices (7-bit index inside the address byte)
	localparam logic [6:0] REG_STATUS = 7'h00;
	localparam logic [6:0] REG_FLAGS  = 7'h01;
	localparam logic [6:0] REG_CTRL   = 7'h02;
	// Module register fields and reset values
	localparam int ST_NOT_READY  = 0;
	localparam int ST_HIGH_POWER = 1;
	localparam int ST_INIT_MODE  = 2;
	localparam int FL_RESET_DONE = 0;
	localparam int FL_FAULT      = 1;
	localparam int CT_HP_ENABLE  = 0;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [1:0] FLAGS_RESET = 2'h0;
	// Host controller APB map (byte addresses)
	localparam logic [11:0] HA_CMD     = 12'h000;
	localparam logic [11:0] HA_STAT    = 12'h004;
	localparam logic [11:0] HA_PINCTL  = 12'h008;
	localparam logic [11:0] HA_PINSTAT = 12'h00C;
	// Host controller fields
	localparam int CMD_RW        = 7;
	localparam int CMD_WDATA_LSB = 8;
	localparam int STAT_BUSY     = 0;
	localparam int STAT_NACK     = 1;
	localparam int STAT_RDATA_LSB = 8;
	localparam int PC_SELECT     = 0;
	localparam int PC_RESET      = 1;
	localparam int PC_MODE_DRIVE = 2;
	localparam int PC_MODE_LEVEL = 3;
	localparam logic [3:0] PINCTL_RESET = 4'h0;
	localparam int PS_PRESENT    = 0;
	localparam int PS_ALERT      = 1;
endpackage : mod_sideband_pkg

// file: module_link_if.sv
// Pins between host board and pluggable module, with wire resolution
`timescale 1ns/100ps
`default_nettype none
interface module_link_if;
	logic scl;
	logic sdaHostOut, sdaHostOe, sdaDevOut, sdaDevOe;
	logic module_select_n, module_reset_n;
	logic pucsOut, pucsOe;
	logic presentOut, presentOe;
	logic faultOut, faultOe;
	wire  sda, power_up_control_select, module_present_n, fault_alert_n;

	// Open-drain lines with pull-ups; mode pin pulled up inside the module
	assign sda = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));
	assign power_up_control_select = pucsOe ? pucsOut : 1'b1;
	assign module_present_n = presentOe ? presentOut : 1'b1;
	assign fault_alert_n = ~(faultOe & ~faultOut);

	modport dev (input scl, sda, module_select_n, module_reset_n,
		power_up_control_select,
		output sdaDevOut, sdaDevOe, presentOut, presentOe, faultOut, faultOe);
	modport host (input sda, module_present_n, fault_alert_n,
		output scl, sdaHostOut, sdaHostOe, module_select_n, module_reset_n,
		pucsOut, pucsOe);
endinterface : module_link_if
`default_nettype wire

// file: sync2.sv
// Two-flop synchroniser for a bundle of independent levels
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// Levels
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second stage; reset to the idle levels
	// so that no false edge is seen once reset lets go
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= RST_VAL;
			dout   <= RST_VAL;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule : sync2
`default_nettype wire

// file: module_end.sv
// Module end: select gating, reset filter, init sequence, alert and registers
`timescale 1ns/100ps
`default_nettype none
module module_end
	import mod_sideband_pkg::*;
#(
	parameter int RST_FILTER = mod_sideband_pkg::RST_FILTER_CYC,
	parameter int INIT_WAIT  = mod_sideband_pkg::INIT_CYC
) (
	// Module internal clock and power-up reset
	input  wire logic clk,
	input  wire logic rstn,
	// Host-facing pins
	module_link_if.dev lnk,
	// Module core side
	input  wire logic faultEvent,
	output logic      highPowerEn,
	output logic      dataNotReady,
	output logic      softwareMode
);
	import mod_sideband_pkg::*;

	typedef enum logic [1:0] {
		INIT  = 2'b01,
		READY = 2'b10
	} mstate_t;

	localparam int FW = $clog2(RST_FILTER + 1);
	localparam int IW = $clog2(INIT_WAIT + 1);
	// Idle pin levels: lines high, crossing toggles low
	localparam logic [6:0] PIN_IDLE = 7'h7C;

	mstate_t      state_q, state_d;
	logic [FW-1:0] filtCnt_q;
	logic [IW-1:0] initCnt_q;
	logic [7:0]   ctrl_q, rdWord_q;
	logic [1:0]   flags_q;
	logic         frameActive_q, sdaPrev_q, wrTogPrev_q, rdTogPrev_q;
	// Serial clock domain state
	logic [4:0]   bitCnt_q;
	logic [7:0]   sh_q, addr_q, wrData_q;
	logic         wrTog_q, rdTog_q, sdaLow_q;

	// Synchronised pins and toggles
	logic sclS, sdaS, selNS, rstPinS, modeS, wrTogS, rdTogS;
	sync2 #(.W(7), .RST_VAL(PIN_IDLE)) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.din  ({lnk.scl, lnk.sda, lnk.module_select_n, lnk.module_reset_n,
			lnk.power_up_control_select, wrTog_q, rdTog_q}),
		.dout ({sclS, sdaS, selNS, rstPinS, modeS, wrTogS, rdTogS})
	);

	// Frame edges and select gating
	wire startSeen  = sclS & sdaPrev_q & ~sdaS;
	wire stopSeen   = sclS & ~sdaPrev_q & sdaS;
	wire linkRstn   = frameActive_q;
	wire wrStrobe   = wrTogS ^ wrTogPrev_q;
	wire rdStrobe   = rdTogS ^ rdTogPrev_q;
	wire [6:0] idx  = addr_q[7:1];
	wire isRead     = addr_q[0];

	// Reset filter and init sequence
	wire softRst    = (filtCnt_q == FW'(RST_FILTER));
	wire initDone   = (initCnt_q == IW'(INIT_WAIT));
	wire ready      = (state_q == READY);
	wire enterReady = (state_q == INIT) & initDone & ~softRst;

	// Event flags: a new event wins over a clear-on-read
	wire [1:0] setFlags = {faultEvent, enterReady};
	wire [1:0] clrFlags = (rdStrobe & isRead & (idx == REG_FLAGS)) ?
		2'b11 : 2'b00;

	// Readback word
	wire [7:0] statusWord = {5'h00, modeS, highPowerEn, ~ready};
	wire [7:0] readMux = (idx == REG_STATUS) ? statusWord :
		(idx == REG_FLAGS) ? {6'h00, flags_q} :
		(idx == REG_CTRL) ? ctrl_q : 8'h00;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			INIT:  if (enterReady) state_d = READY;
			READY: if (softRst) state_d = INIT;
		endcase
	end

	// Software mode waits for the enable bit, hardware mode goes at once
	wire hpNext = ready & (~modeS | ctrl_q[CT_HP_ENABLE]);

	// Outputs to the module core, from flops so the core sees no glitches
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dataNotReady <= 1'b1;
			softwareMode <= 1'b1;
			highPowerEn  <= 1'b0;
		end else begin
			dataNotReady <= ~ready;
			softwareMode <= modeS;
			highPowerEn  <= hpNext;
		end
	end

	// Pins the module drives: presence always low, alert and sda pulled low only when active
	assign lnk.presentOut = 1'b0;
	assign lnk.presentOe  = 1'b1;
	assign lnk.faultOut   = 1'b0;
	assign lnk.faultOe    = |flags_q;
	assign lnk.sdaDevOut  = 1'b0;
	assign lnk.sdaDevOe   = sdaLow_q;

	// Frame tracking; traffic is ignored while deselected
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sdaPrev_q     <= 1'b1;
			frameActive_q <= 1'b0;
		end else begin
			sdaPrev_q <= sdaS;
			if (selNS | stopSeen)
				frameActive_q <= 1'b0;
			else if (startSeen)
				frameActive_q <= 1'b1;
		end
	end

	// Reset pin filter: only a low held RST_FILTER cycles resets
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			filtCnt_q <= '0;
		else if (rstPinS)
			filtCnt_q <= '0;
		else if (!softRst)
			filtCnt_q <= filtCnt_q + FW'(1);
	end

	// Management interface init count, restarted by every reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q   <= INIT;
			initCnt_q <= '0;
		end else begin
			state_q <= state_d;
			if (softRst)
				initCnt_q <= '0;
			else if (!initDone)
				initCnt_q <= initCnt_q + IW'(1);
		end
	end

	// Register file in the module clock domain
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q      <= CTRL_RESET;
			flags_q     <= FLAGS_RESET;
			rdWord_q    <= 8'h00;
			wrTogPrev_q <= 1'b0;
			rdTogPrev_q <= 1'b0;
		end else begin
			wrTogPrev_q <= wrTogS;
			rdTogPrev_q <= rdTogS;
			if (rdStrobe)
				rdWord_q <= readMux;
			if (softRst) begin
				ctrl_q  <= CTRL_RESET;
				flags_q <= FLAGS_RESET;
			end else begin
				flags_q <= (flags_q & ~clrFlags) | setFlags;
				if (wrStrobe & ~isRead & (idx == REG_CTRL))
					ctrl_q <= wrData_q;
			end
		end
	end

	// Serial receive on rising serial clock; idle between frames
	wire addrEdge = (bitCnt_q == ADDR_DONE - 5'h01);
	wire dataEdge = (bitCnt_q == DATA_DONE - 5'h01);
	always_ff @(posedge lnk.scl or negedge linkRstn) begin
		if (!linkRstn) begin
			bitCnt_q <= 5'h00;
			sh_q     <= 8'h00;
		end else begin
			sh_q <= {sh_q[6:0], lnk.sda};
			if (bitCnt_q != FRAME_BITS)
				bitCnt_q <= bitCnt_q + 5'h01;
		end
	end

	// Address and write data words, held stable across the crossing
	always_ff @(posedge lnk.scl or negedge rstn) begin
		if (!rstn) begin
			addr_q   <= 8'h00;
			wrData_q <= 8'h00;
			wrTog_q  <= 1'b0;
			rdTog_q  <= 1'b0;
		end else if (linkRstn) begin
			if (addrEdge) begin
				addr_q  <= {sh_q[6:0], lnk.sda};
				rdTog_q <= ~rdTog_q;
			end
			if (dataEdge & ~isRead) begin
				wrData_q <= {sh_q[6:0], lnk.sda};
				wrTog_q  <= ~wrTog_q;
			end
		end
	end

	// Data drive on falling serial clock: ack slots and read bits
	// rdWord_q settles a few clk cycles after the address byte, well
	// before the first read bit is driven
	wire dataSlot = (bitCnt_q > ADDR_DONE) & (bitCnt_q < DATA_DONE);
	wire [4:0] rdPos = DATA_DONE - 5'h01 - bitCnt_q;
	wire rdBit = rdWord_q[rdPos[2:0]];
	wire driveLow = (bitCnt_q == ADDR_DONE) |
		(isRead & dataSlot & ~rdBit) |
		(~isRead & (bitCnt_q == DATA_DONE));
	always_ff @(negedge lnk.scl or negedge linkRstn) begin
		if (!linkRstn)
			sdaLow_q <= 1'b0;
		else
			sdaLow_q <= driveLow;
	end
endmodule : module_end
`default_nettype wire

// file: host_end.sv
// Host end: APB-controlled serial master and sideband pin control
`timescale 1ns/100ps
`default_nettype none
module host_end
	import mod_sideband_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Module pins
	module_link_if.host lnk
);
	import mod_sideband_pkg::*;

	typedef enum logic [3:0] {
		IDLE  = 4'b0001,
		START = 4'b0010,
		BITS  = 4'b0100,
		STOP  = 4'b1000
	} hstate_t;

	localparam int QW = $clog2(QUARTER_CYC + 1);
	// Pin levels while nothing pulls: sda, presence and alert all high
	localparam logic [2:0] PIN_IDLE = 3'h7;

	hstate_t       state_q;
	logic [QW-1:0] qCnt_q;
	logic [1:0]    sub_q;
	logic [4:0]    bit_q;
	logic [15:0]   cmd_q;
	logic [7:0]    rdata_q;
	logic [3:0]    pinCtl_q;
	logic          sclOut_q, sdaLow_q, nack_q;
	logic          sdaS, presS, alertS;

	sync2 #(.W(3), .RST_VAL(PIN_IDLE)) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.din  ({lnk.sda, lnk.module_present_n, lnk.fault_alert_n}),
		.dout ({sdaS, presS, alertS})
	);

	// APB decode; zero-wait answers
	wire access   = psel & penable;
	wire hitCmd   = (paddr == HA_CMD);
	wire hitStat  = (paddr == HA_STAT);
	wire hitCtl   = (paddr == HA_PINCTL);
	wire hitPin   = (paddr == HA_PINSTAT);
	wire mapped   = hitCmd | hitStat | hitCtl | hitPin;
	wire busy     = (state_q != IDLE);
	wire launch   = access & pwrite & hitCmd & ~busy;
	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;
	assign prdata  = hitCmd ? {16'h0000, cmd_q} :
		hitStat ? {16'h0000, rdata_q, 6'h00, nack_q, busy} :
		hitCtl ? {28'h0000000, pinCtl_q} :
		hitPin ? {30'h00000000, ~alertS, ~presS} : 32'h00000000;

	// Pin drive; mode pin floats unless enabled, leaving it pulled high
	assign lnk.scl             = sclOut_q;
	assign lnk.sdaHostOut      = 1'b0;
	assign lnk.sdaHostOe       = sdaLow_q;
	assign lnk.module_select_n = ~pinCtl_q[PC_SELECT];
	assign lnk.module_reset_n  = ~pinCtl_q[PC_RESET];
	assign lnk.pucsOut         = pinCtl_q[PC_MODE_LEVEL];
	assign lnk.pucsOe          = pinCtl_q[PC_MODE_DRIVE];

	// Bit selection for the frame being sent
	wire tick      = (qCnt_q == QW'(QUARTER_CYC - 1));
	wire isRead    = cmd_q[CMD_RW];
	wire [4:0] aPos = ADDR_DONE - 5'h01 - bit_q;
	wire [4:0] dPos = DATA_DONE - 5'h01 - bit_q;
	wire inAddr    = (bit_q < ADDR_DONE);
	wire inData    = (bit_q > ADDR_DONE) & (bit_q < DATA_DONE);
	wire [7:0] wrByte = cmd_q[CMD_WDATA_LSB +: 8];
	// Index goes out first, the direction bit last
	wire [7:0] addrByte = {cmd_q[CMD_RW-1:0], cmd_q[CMD_RW]};
	wire drive0    = inAddr ? ~addrByte[aPos[2:0]] :
		(inData & ~isRead) ? ~wrByte[dPos[2:0]] : 1'b0;
	wire lastBit   = (bit_q == FRAME_BITS - 5'h01);
	wire ackCheck  = (bit_q == ADDR_DONE) |
		(~isRead & (bit_q == DATA_DONE));

	// Register writes; commands issued while busy are dropped
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmd_q    <= 16'h0000;
			pinCtl_q <= PINCTL_RESET;
		end else if (access & pwrite) begin
			if (launch)
				cmd_q <= pwdata[15:0];
			if (hitCtl)
				pinCtl_q <= pwdata[3:0];
		end
	end

	// Quarter-period timebase for the serial clock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			qCnt_q <= '0;
		else if (launch | tick)
			qCnt_q <= '0;
		else
			qCnt_q <= qCnt_q + QW'(1);
	end

	// Serial master: start, 18 bit slots, stop
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q  <= IDLE;
			sub_q    <= 2'h0;
			bit_q    <= 5'h00;
			sclOut_q <= 1'b1;
			sdaLow_q <= 1'b0;
			nack_q   <= 1'b0;
			rdata_q  <= 8'h00;
		end else if (launch) begin
			state_q <= START;
			sub_q   <= 2'h0;
			nack_q  <= 1'b0;
		end else if (tick & busy) begin
			sub_q <= sub_q + 2'h1;
			unique case (state_q)
				START: begin
					if (sub_q == 2'h0) sdaLow_q <= 1'b1;
					if (sub_q == 2'h2) sclOut_q <= 1'b0;
					if (sub_q == 2'h3) begin
						state_q <= BITS;
						bit_q   <= 5'h00;
					end
				end
				BITS: begin
					if (sub_q == 2'h0) sdaLow_q <= drive0;
					if (sub_q == 2'h1) sclOut_q <= 1'b1;
					if (sub_q == 2'h2) begin
						if (ackCheck & sdaS) nack_q <= 1'b1;
						if (inData & isRead)
							rdata_q <= {rdata_q[6:0], sdaS};
					end
					if (sub_q == 2'h3) begin
						sclOut_q <= 1'b0;
						if (lastBit) state_q <= STOP;
						else bit_q <= bit_q + 5'h01;
					end
				end
				STOP: begin
					if (sub_q == 2'h0) sdaLow_q <= 1'b1;
					if (sub_q == 2'h1) sclOut_q <= 1'b1;
					if (sub_q == 2'h2) sdaLow_q <= 1'b0;
					if (sub_q == 2'h3) state_q <= IDLE;
				end
				default: state_q <= IDLE;
			endcase
		end
	end
endmodule : host_end
`default_nettype wire

// file: module_sideband_props.sv
// Checker on the pins between host end and module end
`timescale 1ns/100ps
`default_nettype none
module module_sideband_props #(
	parameter int RST_FILTER = 4,
	parameter int INIT_WAIT  = 20
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Link pins
	input wire logic scl,
	input wire logic module_select_n,
	input wire logic module_reset_n,
	input wire logic power_up_control_select,
	input wire logic module_present_n,
	input wire logic fault_alert_n,
	input wire logic sdaDevOut,
	input wire logic sdaDevOe,
	input wire logic pucsOe,
	input wire logic faultOut,
	input wire logic faultOe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// Longest wait from reset release to the completion alert
	localparam int DONE_MAX = INIT_WAIT + 2 * RST_FILTER + 12;

	// Cycles since power-up reset, saturating so it never wraps
	logic [15:0] upCnt_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) upCnt_q <= 16'h0000;
		else if (upCnt_q != 16'hFFFF) upCnt_q <= upCnt_q + 16'h0001;
	end

	// Reset pin shapes; the short one stays under a filter of four
	sequence longLow;
		(!module_reset_n)[*8];
	endsequence
	sequence shortPulse;
		(faultOe && module_reset_n) ##1 (!module_reset_n)[*3]
			##1 module_reset_n;
	endsequence

	AST_PRESENT_LOW: assert property (module_present_n == 1'b0)
		else $error("presence pin not low");
	AST_ALERT_OPEN_DRAIN: assert property (!faultOut &&
		(fault_alert_n == !faultOe)) else $error("alert drives high");
	AST_SDA_OPEN_DRAIN: assert property (!sdaDevOut)
		else $error("module drives sda high");
	AST_SDA_CHANGES_SCL_LOW: assert property (
		$changed(sdaDevOe) |-> !scl)
		else $error("module data moved while scl high");
	AST_MODE_PULLUP: assert property (
		!pucsOe |-> power_up_control_select)
		else $error("undriven mode pin not high");
	AST_MODE_STEADY: assert property (
		$changed(power_up_control_select) |-> !module_reset_n)
		else $error("mode pin moved outside reset");
	AST_NO_ACK_UNSELECTED: assert property ($rose(sdaDevOe)
		|-> !module_select_n) else $error("answer while deselected");
	AST_RESET_CLEARS: assert property (
		longLow |-> ##[0:4] !faultOe)
		else $error("long reset kept alert");
	AST_SHORT_IGNORED: assert property (
		shortPulse |-> faultOe[*6])
		else $error("short reset pulse acted");
	AST_RESET_DONE: assert property (longLow ##1 module_reset_n
		|-> ##[1:DONE_MAX] faultOe) else $error("no completion after reset");
	AST_POWERUP_DONE: assert property (upCnt_q == 16'(INIT_WAIT + 8)
		|-> faultOe) else $error("no completion after power-up");
endmodule : module_sideband_props
`default_nettype wire

// file: test_module_sideband_control.sv
// Self-checking bench for both ends of the module sideband link
`timescale 1ns/100ps
`default_nettype none
module test_module_sideband_control;
	import mod_sideband_pkg::*;
	// Bench signals, scoreboard and model state
	logic        clk = 1'b0, rstn = 1'b0, faultEvent = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic        pready, pslverr, lastErr, highPowerEn, dataNotReady;
	logic        softwareMode, nk;
	logic [7:0]  rd, wd;
	integer      seed;
	int          n_mismatch = 0, total_checks = 0, cyc = 0;
	int          mFlags = 1, mCtrl = 0, mMode = 1;
	int          ctrlQ[$];

	// Both ends face each other across the pins
	module_link_if lnk();
	host_end u_host_end(.clk(clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
	module_end #(.RST_FILTER(4), .INIT_WAIT(20)) u_module_end(.clk(clk),
		.rstn(rstn), .lnk(lnk), .faultEvent(faultEvent),
		.highPowerEn(highPowerEn), .dataNotReady(dataNotReady),
		.softwareMode(softwareMode));
	module_sideband_props #(.RST_FILTER(4), .INIT_WAIT(20)) u_props(
		.clk(clk), .rstn(rstn), .scl(lnk.scl),
		.module_select_n(lnk.module_select_n),
		.module_reset_n(lnk.module_reset_n),
		.power_up_control_select(lnk.power_up_control_select),
		.module_present_n(lnk.module_present_n),
		.fault_alert_n(lnk.fault_alert_n), .sdaDevOut(lnk.sdaDevOut),
		.sdaDevOe(lnk.sdaDevOe), .pucsOe(lnk.pucsOe),
		.faultOut(lnk.faultOut), .faultOe(lnk.faultOe));

	// Clock and a cycle ceiling against hangs
	always #(CLK_PERIOD_NS / 2) clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			stop_test();
		end
	end

	// Expected module status from the model
	function automatic logic [7:0] stExp();
		logic hp;
		hp = (mMode == 0) ? 1'b1 : mCtrl[0];
		return {5'h00, mMode[0], hp, 1'b0};
	endfunction : stExp

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One APB transfer; an idle edge follows so the next never collides
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	// One serial frame through the host command register
	task automatic frame(input logic [6:0] idx, input logic rdn,
		input logic [7:0] d, output logic [7:0] q, output logic nack);
		logic [31:0] s;
		int n;
		apb(1'b1, HA_CMD, {16'h0000, d, rdn, idx}, s);
		n = 0;
		do begin
			apb(1'b0, HA_STAT, 32'h0, s);
			n++;
		end while (s[STAT_BUSY] !== 1'b0 && n < 500);
		chk("busy", 32'h0, 32'(s[STAT_BUSY]));
		q = s[15:8];
		nack = s[STAT_NACK];
	endtask : frame

	task automatic regRd(input logic [6:0] idx, input logic [7:0] e);
		logic [7:0] q;
		logic nack;
		frame(idx, 1'b1, 8'h00, q, nack);
		chk("regData", 32'(e), 32'(q));
		chk("regNack", 32'h0, 32'(nack));
	endtask : regRd

	task automatic pins(input logic [3:0] v);
		logic [31:0] q;
		apb(1'b1, HA_PINCTL, 32'(v), q);
	endtask : pins

	// Host waits for the alert before trusting any status
	task automatic waitAlert();
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			apb(1'b0, HA_PINSTAT, 32'h0, q);
			n++;
		end while (q[PS_ALERT] !== 1'b1 && n < 200);
		chk("alert", 32'h1, 32'(q[PS_ALERT]));
	endtask : waitAlert

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// Main sequence
	initial begin
		seed = 32'hE88C;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		waitAlert();
		chk("notReady", 32'h0, 32'(dataNotReady));
		apb(1'b0, HA_PINSTAT, 32'h0, r);
		chk("pinstat", 32'h3, r);
		chk("swMode", 32'h1, 32'(softwareMode));
		chk("hpEn", 32'h0, 32'(highPowerEn));
		pins(4'h1);
		apb(1'b0, HA_PINCTL, 32'h0, r);
		chk("pinctl", 32'h1, r);
		regRd(REG_STATUS, stExp());
		regRd(7'h03, 8'h00);
		regRd(REG_FLAGS, 8'(mFlags));
		mFlags = 0;
		apb(1'b0, HA_PINSTAT, 32'h0, r);
		chk("pinstat", 32'h1, r);
		for (int i = 0; i < 4; i++) begin
			wd = 8'($random(seed));
			frame(REG_CTRL, 1'b0, wd, rd, nk);
			chk("wrNack", 32'h0, 32'(nk));
			ctrlQ.push_back(int'(wd));
			mCtrl = int'(wd);
			chk("hpEn", 32'(mCtrl & 1), 32'(highPowerEn));
			frame(REG_CTRL, 1'b1, 8'h00, rd, nk);
			chk("ctrl", 32'(ctrlQ.pop_front()), 32'(rd));
		end
		faultEvent <= 1'b1;
		@(posedge clk);
		faultEvent <= 1'b0;
		mFlags = mFlags | 2;
		waitAlert();
		pins(4'h3);
		pins(4'h1);
		repeat (10) @(posedge clk);
		waitAlert();
		chk("hpEn", 32'(mCtrl & 1), 32'(highPowerEn));
		regRd(REG_FLAGS, 8'(mFlags));
		mFlags = 0;
		apb(1'b0, HA_PINSTAT, 32'h0, r);
		chk("pinstat", 32'h1, r);
		// A pending fault must be wiped by the long reset below
		faultEvent <= 1'b1;
		@(posedge clk);
		faultEvent <= 1'b0;
		// Mode is moved only while the module is held in reset
		pins(4'h7);
		mMode = 0;
		mCtrl = 0;
		mFlags = 1;
		repeat (30) @(posedge clk);
		chk("notReady", 32'h1, 32'(dataNotReady));
		pins(4'h5);
		waitAlert();
		chk("notReady", 32'h0, 32'(dataNotReady));
		chk("swMode", 32'h0, 32'(softwareMode));
		chk("hpEn", 32'h1, 32'(highPowerEn));
		regRd(REG_STATUS, stExp());
		frame(REG_CTRL, 1'b1, 8'h00, rd, nk);
		chk("ctrl", 32'(mCtrl), 32'(rd));
		regRd(REG_FLAGS, 8'(mFlags));
		pins(4'h4);
		frame(REG_STATUS, 1'b1, 8'h00, rd, nk);
		chk("nack", 32'h1, 32'(nk));
		apb(1'b0, 12'h010, 32'h0, r);
		chk("slverr", 32'h1, 32'(lastErr));
		chk("unmapped", 32'h0, r);
		stop_test();
	end
endmodule : test_module_sideband_control
`default_nettype wire
